// ---- cwd_core.sv ----
// speed/direction post-processing core driving the output pulse protocol
// assumes samples and strobe come from ADC logic on clk; supply_mod_pin is asynchronous
//
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/1ns
module cwd_core #(
  parameter int REV_CYC = cwd_pkg::CYC_REV,
  parameter int STOP_CYC = cwd_pkg::CYC_STOP,
  parameter int HS_ON_CYC = cwd_pkg::CYC_HS_ON,
  parameter int HS_OFF_CYC = cwd_pkg::CYC_HS_OFF,
  parameter int ALT_ON_CYC = cwd_pkg::CYC_ALT_ON,
  parameter int ALT_OFF_CYC = cwd_pkg::CYC_ALT_OFF,
  parameter int ENTRY_CYC = cwd_pkg::CYC_ENTRY
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic signed [11:0] speed_in,
  input wire logic signed [11:0] dir_in,
  input wire logic sample_stb,
  input wire logic [1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic supply_mod_pin,
  output logic prot_out
);
  import cwd_pkg::*;

  function automatic cwd_s_t sx(input logic signed [11:0] v);
    sx = {v[11], v};
  endfunction

  function automatic cwd_s_t absv(input cwd_s_t v);
    absv = v[SW-1] ? -v : v;
  endfunction

  logic [15:0] cfg_q;
  logic [11:0] hfloor_q, dnc_q;
  logic switch_edge_select, forward_sense_invert, sys_supervisor_enable;
  logic stop_en, hs_en, dir_eighth, alternate_timing_select;
  cwd_hys_t hys_mode;
  assign switch_edge_select = cfg_q[CFG_EDGE];
  assign forward_sense_invert = cfg_q[CFG_FWDINV];
  assign sys_supervisor_enable = cfg_q[CFG_SUP];
  assign stop_en = cfg_q[CFG_STOP];
  assign hs_en = cfg_q[CFG_HS];
  assign dir_eighth = cfg_q[CFG_DIRCHG];
  assign alternate_timing_select = cfg_q[CFG_TSS];
  assign hys_mode = cwd_hys_t'(cfg_q[CFG_HYST +: 2]);

  // speed path
  cwd_ex_t ex_q;
  cwd_s_t s, max_q, min_q, offset_q, hyst, upper, lower, held_q, pp;
  logic above_q, arm_lo_q, arm_hi_q, seen_max, seen_min;
  logic up_x, dn_x, zc, sw_up, sw_dn, sel_x, sw_evt, wd_fire, ss_exit;
  logic ss_active_q, hs_active_q, fwd_q, pulse_q, ser_active_q;
  assign s = sx(speed_in);
  assign pp = max_q - min_q;
  assign hyst = (hys_mode == HYS_FIXED || (pp >>> 2) < sx(hfloor_q)) ? sx(hfloor_q)
              : (pp >>> 2);
  assign upper = offset_q + hyst;
  assign lower = offset_q - hyst;
  assign up_x = sample_stb && s > offset_q && !above_q;
  assign dn_x = sample_stb && s <= offset_q && above_q;
  assign zc = up_x || dn_x;
  assign seen_max = sample_stb && ex_q == EX_RISE && s < max_q && s < max_q - hyst;
  assign seen_min = sample_stb && ex_q == EX_FALL && s > min_q && s > min_q + hyst;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ex_q <= EX_INIT;
      max_q <= '0;
      min_q <= '0;
      offset_q <= '0;
    end else if (wd_fire) begin
      offset_q <= s;
    end else if (ss_exit) begin
      offset_q <= s;
    end else if (sample_stb) begin
      case (ex_q)
        EX_INIT: begin
          max_q <= s;
          min_q <= s;
          offset_q <= s;
          ex_q <= EX_RISE;
        end
        EX_RISE: begin
          if (s > max_q) begin
            max_q <= s;
          end else if (seen_max) begin
            offset_q <= (max_q + min_q) >>> 1;
            min_q <= s;
            ex_q <= EX_FALL;
          end
        end
        EX_FALL: begin
          if (s < min_q) begin
            min_q <= s;
          end else if (seen_min) begin
            offset_q <= (max_q + min_q) >>> 1;
            max_q <= s;
            ex_q <= EX_RISE;
          end
        end
        default: ex_q <= EX_INIT;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      above_q <= 1'b0;
    end else if (sample_stb) begin
      above_q <= s > offset_q;
    end
  end

  // hysteresis arming; a new arm wins over the clear of a switch
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      arm_lo_q <= 1'b0;
      arm_hi_q <= 1'b0;
    end else if (sample_stb) begin
      if (s < lower) begin
        arm_lo_q <= 1'b1;
      end else if (sw_up) begin
        arm_lo_q <= 1'b0;
      end
      if (s > upper) begin
        arm_hi_q <= 1'b1;
      end else if (sw_dn) begin
        arm_hi_q <= 1'b0;
      end
    end
  end

  assign sw_up = arm_lo_q && (hys_mode == HYS_VISIBLE ? sample_stb && s > upper : up_x);
  assign sw_dn = arm_hi_q && (hys_mode == HYS_VISIBLE ? sample_stb && s < lower : dn_x);
  assign sel_x = switch_edge_select ? dn_x : up_x;
  assign sw_evt = (switch_edge_select ? sw_dn : sw_up) && !ss_active_q && !pulse_q;

  // direction detection
  cwd_s_t first_q, diff, mag;
  cwd_s_t hist_q [AVG_TEETH];
  logic [15:0] sum, avg;
  logic [SW-1:0] dthr;
  logic dir_full, fwd_d;
  always_comb begin
    sum = '0;
    for (int i = 0; i < AVG_TEETH; i++) begin
      sum = sum + 16'(hist_q[i]);
    end
  end
  assign avg = 16'((32'(sum) * 32'd205) >> 10);
  assign dthr = dir_eighth ? SW'(avg >> 3) : SW'(avg >> 2);
  assign diff = first_q - sx(dir_in);
  assign mag = absv(diff);
  assign dir_full = mag >= cwd_s_t'(dthr);
  // direction of this crossing, so its own pulse carries it
  assign fwd_d = (sel_x && !hs_active_q)
               ? (dir_full ? (!diff[SW-1] ^ forward_sense_invert) : !fwd_q)
               : fwd_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      first_q <= '0;
      fwd_q <= 1'b1;
      for (int i = 0; i < AVG_TEETH; i++) begin
        hist_q[i] <= '0;
      end
    end else if (zc && !sel_x) begin
      first_q <= sx(dir_in);
    end else if (sel_x) begin
      if (dir_full) begin
        hist_q[0] <= mag;
        for (int i = 1; i < AVG_TEETH; i++) begin
          hist_q[i] <= hist_q[i-1];
        end
      end
      fwd_q <= fwd_d;
    end
  end

  // high speed mode
  logic [16:0] per_q;
  logic [1:0] hs_cnt_q;
  logic [16:0] on_lim, off_lim;
  assign on_lim = alternate_timing_select ? 17'(ALT_ON_CYC) : 17'(HS_ON_CYC);
  assign off_lim = alternate_timing_select ? 17'(ALT_OFF_CYC) : 17'(HS_OFF_CYC);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      per_q <= '0;
      hs_cnt_q <= '0;
      hs_active_q <= 1'b0;
    end else if (sel_x) begin
      per_q <= '0;
      if (!hs_en || per_q > off_lim) begin
        hs_cnt_q <= '0;
        hs_active_q <= 1'b0;
      end else if (per_q < on_lim) begin
        if (hs_cnt_q + 2'h1 >= HS_MEAS) begin
          hs_active_q <= 1'b1;
        end
        if (hs_cnt_q != HS_MEAS) begin
          hs_cnt_q <= hs_cnt_q + 2'h1;
        end
      end
    end else if (per_q != '1) begin
      per_q <= per_q + 17'h1;
    end
  end

  // output pulse
  logic [12:0] plen_q;
  logic [12:0] pl_target;
  assign pl_target = fwd_d ? 13'(CYC_FWD) : 13'(REV_CYC);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pulse_q <= 1'b0;
      plen_q <= '0;
    end else if (sw_evt) begin
      pulse_q <= 1'b1;
      plen_q <= pl_target;
    end else if (pulse_q) begin
      if (plen_q == 13'h1) begin
        pulse_q <= 1'b0;
      end
      plen_q <= plen_q - 13'h1;
    end
  end

  // system supervisor
  logic [2:0] wd_cnt_q;
  logic wmax_q, wmin_q, wd_inc;
  assign wd_inc = sys_supervisor_enable && zc && wmax_q && wmin_q && !sw_evt;
  assign wd_fire = wd_inc && wd_cnt_q + 3'h1 == WDOG_LIMIT;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wd_cnt_q <= '0;
      wmax_q <= 1'b0;
      wmin_q <= 1'b0;
    end else begin
      if (zc && wmax_q && wmin_q) begin
        wmax_q <= seen_max;
        wmin_q <= seen_min;
      end else begin
        wmax_q <= wmax_q || seen_max;
        wmin_q <= wmin_q || seen_min;
      end
      if (sw_evt || wd_fire || !sys_supervisor_enable) begin
        wd_cnt_q <= '0;
      end else if (wd_inc) begin
        wd_cnt_q <= wd_cnt_q + 3'h1;
      end
    end
  end

  // stop-start supervisor
  logic [26:0] ss_tmr_q;
  assign ss_exit = ss_active_q && sample_stb && absv(s - held_q) > sx(dnc_q);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ss_tmr_q <= '0;
      ss_active_q <= 1'b0;
      held_q <= '0;
    end else begin
      if (zc || ss_exit) begin
        ss_tmr_q <= '0;
      end else if (ss_tmr_q != '1) begin
        ss_tmr_q <= ss_tmr_q + 27'h1;
      end
      if (ss_exit || !stop_en) begin
        ss_active_q <= 1'b0;
      end else if (!ss_active_q && ss_tmr_q >= 27'(STOP_CYC)) begin
        ss_active_q <= 1'b1;
        held_q <= s;
      end
    end
  end

  // supply-modulated serial interface
  logic [2:0] mod_sync_q;
  logic mod_rise, mod_fall, ser_bit;
  logic [3:0] hi_cnt_q;
  logic [15:0] win_q, ser_sh_q, status;
  logic [7:0] cmd_q;
  assign mod_rise = mod_sync_q[1] && !mod_sync_q[2];
  assign mod_fall = !mod_sync_q[1] && mod_sync_q[2];
  // a long high phase of the supply is a one
  assign ser_bit = hi_cnt_q >= 4'(SER_ONE_CYC);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mod_sync_q <= '0;
      win_q <= '0;
      cmd_q <= '0;
      ser_active_q <= 1'b0;
      ser_sh_q <= '0;
      hi_cnt_q <= '0;
    end else begin
      mod_sync_q <= {mod_sync_q[1:0], supply_mod_pin};
      if (!mod_sync_q[1]) begin
        hi_cnt_q <= '0;
      end else if (hi_cnt_q != 4'hF) begin
        hi_cnt_q <= hi_cnt_q + 4'h1;
      end
      if (win_q != 16'(ENTRY_CYC)) begin
        win_q <= win_q + 16'h1;
      end
      if (mod_fall && !ser_active_q) begin
        cmd_q <= {cmd_q[6:0], ser_bit};
        if ({cmd_q[6:0], ser_bit} == ENTRY_CMD && win_q != 16'(ENTRY_CYC)) begin
          ser_active_q <= 1'b1;
          ser_sh_q <= status;
        end
      end else if (mod_rise && ser_active_q) begin
        ser_sh_q <= {ser_sh_q[14:0], ser_sh_q[15]};
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prot_out <= 1'b1;
    end else begin
      prot_out <= ser_active_q ? ser_sh_q[15] : !(sw_evt || (pulse_q && plen_q != 13'h1));
    end
  end

  // register port
  assign status = {9'h0, ser_active_q, ss_active_q, hs_active_q, fwd_q, wd_cnt_q};
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfg_q <= CFG_RST;
      hfloor_q <= HFLOOR_RST;
      dnc_q <= DNC_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        REG_CFG: cfg_q <= {7'h0, reg_wdata[8:0]};
        REG_HFLOOR: hfloor_q <= reg_wdata[11:0];
        REG_DNC: dnc_q <= reg_wdata[11:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        REG_CFG: reg_rdata <= cfg_q;
        REG_HFLOOR: reg_rdata <= {4'h0, hfloor_q};
        REG_DNC: reg_rdata <= {4'h0, dnc_q};
        default: reg_rdata <= status;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  // checks
  logic [12:0] run_q, exp_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      run_q <= '0;
      exp_q <= '0;
    end else if (sw_evt) begin
      run_q <= 13'h0;
      exp_q <= pl_target;
    end else if (pulse_q) begin
      run_q <= run_q + 13'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_pulse_len;
    $fell(pulse_q) |-> run_q == exp_q;
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("pulse length wrong");
  property p_wd_clear;
    sw_evt |=> wd_cnt_q == 3'h0;
  endproperty
  a_wd_clear: assert property (p_wd_clear) else $error("supervisor not cleared");
  property p_wd_inc;
    wd_inc && !wd_fire |=> wd_cnt_q == $past(wd_cnt_q) + 3'h1;
  endproperty
  a_wd_inc: assert property (p_wd_inc) else $error("supervisor not counted");
  property p_wd_fire;
    wd_fire |=> offset_q == $past(s) && wd_cnt_q == 3'h0;
  endproperty
  a_wd_fire: assert property (p_wd_fire) else $error("offset not reset");
  property p_ss_enter;
    stop_en && !ss_active_q && ss_tmr_q >= 27'(STOP_CYC) |=> ss_active_q;
  endproperty
  a_ss_enter: assert property (p_ss_enter) else $error("stop state not entered");
  property p_ss_quiet;
    ss_active_q |-> !sw_evt ##1 !$rose(pulse_q);
  endproperty
  a_ss_quiet: assert property (p_ss_quiet) else $error("switch during stop");
  property p_hs_hold;
    hs_active_q && $past(hs_active_q) |-> $stable(fwd_q);
  endproperty
  a_hs_hold: assert property (p_hs_hold) else $error("direction moved at high speed");
  property p_hyst_floor;
    hyst >= sx(hfloor_q);
  endproperty
  a_hyst_floor: assert property (p_hyst_floor) else $error("hysteresis below floor");
  property p_arm_clear;
    sw_up && !(s < lower) |=> !arm_lo_q;
  endproperty
  a_arm_clear: assert property (p_arm_clear) else $error("arm not consumed");
  property p_out_idle;
    !ser_active_q && !pulse_q && !sw_evt ##1 !ser_active_q |-> prot_out;
  endproperty
  a_out_idle: assert property (p_out_idle) else $error("output low without pulse");

  c_fwd: cover property (sw_evt && fwd_q);
  c_rev: cover property (sw_evt && !fwd_q);
  c_ss: cover property ($rose(ss_active_q));
  c_hs: cover property ($rose(hs_active_q));
endmodule

// ---- cwd_core_tb.sv ----
// self-checking bench for the direction/switch core
// assumes cwd_pkg, cwd_core and cwd_ecu_model are compiled first
`timescale 1ns/1ns
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module cwd_core_tb;
  import cwd_pkg::*;
  localparam int REV = 40;
  localparam logic signed [11:0] PK = 12'h190;
  localparam logic signed [11:0] DF = 12'h12C;
  localparam logic signed [11:0] DS = 12'h032;
  localparam int STOP = 200;
  localparam int HS_ON = 30;
  localparam int HS_OFF = 40;
  localparam int ALT_ON = 20;
  localparam int ALT_OFF = 25;
  localparam int ENTRY = 500;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic signed [11:0] speed_in = 12'h000;
  logic signed [11:0] dir_in = 12'h000;
  logic sample_stb = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic supply_mod_pin = 1'b0;
  logic [1:0] reg_addr = 2'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata, pulse_cnt, last_width, d, n0;
  logic prot_out;
  int bad_count = 0;
  int cmp_count = 0;
  always #10 clk = ~clk;
  cwd_core #(.REV_CYC(REV), .STOP_CYC(STOP), .HS_ON_CYC(HS_ON), .HS_OFF_CYC(HS_OFF),
    .ALT_ON_CYC(ALT_ON), .ALT_OFF_CYC(ALT_OFF), .ENTRY_CYC(ENTRY)) uut (.clk(clk), .nrst(nrst),
    .speed_in(speed_in), .dir_in(dir_in), .sample_stb(sample_stb), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .supply_mod_pin(supply_mod_pin), .prot_out(prot_out));
  cwd_ecu_model ecu (.clk(clk), .nrst(nrst), .line(prot_out), .pulse_cnt(pulse_cnt),
    .last_width(last_width));
  task automatic wr(input logic [1:0] a, input logic [15:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, output logic [15:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic st(input int b, input logic e);
    rd(REG_STATUS, d);
    `CHK("status bit", e, d[b])
  endtask
  task automatic smp(input logic signed [11:0] s, input logic signed [11:0] v, input int g);
    @(posedge clk);
    speed_in <= s;
    dir_in <= v;
    sample_stb <= 1'b1;
    @(posedge clk);
    sample_stb <= 1'b0;
    repeat (g) @(posedge clk);
  endtask
  // command bits msb first, a one is a long high phase
  task automatic send_cmd(input logic [7:0] c);
    for (int i = 7; i >= 0; i--) begin
      @(posedge clk);
      supply_mod_pin <= 1'b1;
      repeat (c[i] ? 12 : 4) @(posedge clk);
      supply_mod_pin <= 1'b0;
      repeat (6) @(posedge clk);
    end
  endtask
  // one tooth: falling crossing then rising crossing
  task automatic tooth(input logic signed [11:0] a, input logic signed [11:0] b,
      input int g, input int k);
    repeat (k) begin
      smp(-PK, a, g);
      smp(PK, b, g);
    end
  endtask
  task automatic wid(input logic [15:0] e);
    repeat (1300) @(posedge clk);
    `CHK("pulse width", e, last_width)
  endtask
  task automatic complete_run;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge clk);
    bad_count++;
    complete_run();
  end
  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    rd(REG_CFG, d);
    `CHK("cfg reset", 16'h001A, d)
    rd(REG_HFLOOR, d);
    `CHK("floor reset", 16'h0010, d)
    rd(REG_DNC, d);
    `CHK("limit reset", 16'h0020, d)
    wr(REG_CFG, 16'hFFFF);
    rd(REG_CFG, d);
    `CHK("cfg mask", 16'h01FF, d)
    rd(REG_STATUS, n0);
    wr(REG_STATUS, 16'hFFFF);
    rd(REG_STATUS, d);
    `CHK("status read only", n0, d)
    // late entry attempt must stay ignored
    repeat (500) @(posedge clk);
    send_cmd(ENTRY_CMD);
    repeat (4) @(posedge clk);
    st(6, 1'b0);
    `CHK("line idle", 1'b1, prot_out)
    wr(REG_CFG, 16'h0000);
    n0 = pulse_cnt;
    tooth(DF, -DF, 1200, 6);
    wid(CYC_FWD);
    `CHK("pulse count", 1'b1, (pulse_cnt - n0) >= 16'h0005)
    st(3, 1'b1);
    `CHK("supervisor count", 3'h0, d[2:0])
    tooth(-DF, DF, 1200, 3);
    wid(REV);
    tooth(DF, -DF, 1200, 1);
    wid(CYC_FWD);
    tooth(DS, -DS, 1200, 1);
    wid(REV);
    tooth(DF, -DF, 1200, 1);
    wid(CYC_FWD);
    wr(REG_CFG, 16'h0020);
    tooth(DS, -DS, 1200, 1);
    wid(CYC_FWD);
    wr(REG_CFG, 16'h0002);
    tooth(DF, -DF, 1200, 2);
    wid(REV);
    wr(REG_CFG, 16'h0003);
    tooth(DF, -DF, 1200, 2);
    `CHK("line before fall", 1'b1, prot_out)
    smp(-PK, DF, 1);
    #1 `CHK("line at fall", 1'b0, prot_out)
    smp(PK, -DF, 1200);
    wid(CYC_FWD);
    wr(REG_CFG, 16'h0010);
    tooth(DF, -DF, 1200, 2);
    tooth(DF, -DF, 6, 4);
    tooth(-DF, DF, 6, 2);
    st(4, 1'b1);
    st(3, 1'b1);
    tooth(DF, -DF, 1200, 2);
    st(4, 1'b0);
    wr(REG_CFG, 16'h0050);
    tooth(DF, -DF, 12, 4);
    st(4, 1'b0);
    tooth(DF, -DF, 6, 4);
    st(4, 1'b1);
    wr(REG_CFG, 16'h0008);
    smp(-PK, DF, 20);
    smp(12'h000, DF, 2300);
    st(5, 1'b1);
    n0 = pulse_cnt;
    repeat (4) begin
      smp(12'h00A, DF, 20);
      smp(-12'sh00A, -DF, 20);
    end
    `CHK("no pulse in stop", n0, pulse_cnt)
    smp(PK, DF, 20);
    st(5, 1'b0);
    // second reset, then entry inside the window
    @(posedge clk);
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    `CHK("line after reset", 1'b1, prot_out)
    send_cmd(ENTRY_CMD);
    repeat (4) @(posedge clk);
    st(6, 1'b1);
    `CHK("serial line", 1'b0, prot_out)
    complete_run();
  end
endmodule

// ---- cwd_ecu_model.sv ----
// engine controller model reading the output pulse line
// assumes the line idles high and each pulse is a low phase on clk
`timescale 1ns/1ns
module cwd_ecu_model (
  input wire logic clk,
  input wire logic nrst,
  input wire logic line,
  output logic [15:0] pulse_cnt,
  output logic [15:0] last_width
);
  logic [15:0] run_q;
  logic line_q;
  // counts low cycles, latches width on return high
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      run_q <= 16'h0000;
      line_q <= 1'b1;
      pulse_cnt <= 16'h0000;
      last_width <= 16'h0000;
    end else begin
      line_q <= line;
      if (!line) begin
        run_q <= run_q + 16'h0001;
      end else if (!line_q) begin
        last_width <= run_q;
        pulse_cnt <= pulse_cnt + 16'h0001;
        run_q <= 16'h0000;
      end
    end
  end
endmodule

// ---- cwd_pkg.sv ----
// constants, types and register map of the crank wheel direction/switch core
// assumes a 50 MHz system clock and 12-bit signed ADC samples
package cwd_pkg;
  localparam int SW = 13;
  typedef logic signed [SW-1:0] cwd_s_t;
  localparam int CLK_NS = 20;
  localparam int CLK_HZ = 50_000_000;
  localparam int T_FWD_NS = 45000;
  localparam int T_REV_NS = 90000;
  localparam int CYC_FWD = (T_FWD_NS + CLK_NS - 1) / CLK_NS;
  localparam int CYC_REV = (T_REV_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_STOP_MS = 1400;
  localparam int CYC_STOP = T_STOP_MS * (1_000_000 / CLK_NS);
  localparam int F_HS_ON_HZ = 1800;
  localparam int F_HS_OFF_HZ = 1500;
  localparam int F_ALT_ON_HZ = 4300;
  localparam int F_ALT_OFF_HZ = 4000;
  localparam int CYC_HS_ON = CLK_HZ / F_HS_ON_HZ;
  localparam int CYC_HS_OFF = CLK_HZ / F_HS_OFF_HZ;
  localparam int CYC_ALT_ON = CLK_HZ / F_ALT_ON_HZ;
  localparam int CYC_ALT_OFF = CLK_HZ / F_ALT_OFF_HZ;
  localparam int T_ENTRY_US = 1000;
  localparam int CYC_ENTRY = T_ENTRY_US * (1000 / CLK_NS);
  localparam logic [1:0] HS_MEAS = 2'h2;
  localparam int AVG_TEETH = 5;
  localparam logic [2:0] WDOG_LIMIT = 3'h4;
  localparam logic [7:0] ENTRY_CMD = 8'hA5;
  localparam int SER_ONE_CYC = 8;
  // register offsets
  localparam logic [1:0] REG_CFG = 2'h0;
  localparam logic [1:0] REG_HFLOOR = 2'h1;
  localparam logic [1:0] REG_DNC = 2'h2;
  localparam logic [1:0] REG_STATUS = 2'h3;
  // config field positions
  localparam int CFG_EDGE = 0;
  localparam int CFG_FWDINV = 1;
  localparam int CFG_SUP = 2;
  localparam int CFG_STOP = 3;
  localparam int CFG_HS = 4;
  localparam int CFG_DIRCHG = 5;
  localparam int CFG_TSS = 6;
  localparam int CFG_HYST = 7;
  localparam logic [15:0] CFG_RST = 16'h001A;
  localparam logic [11:0] HFLOOR_RST = 12'h010;
  localparam logic [11:0] DNC_RST = 12'h020;
  typedef enum logic [1:0] {HYS_HIDDEN = 2'b00, HYS_VISIBLE = 2'b01, HYS_FIXED = 2'b10} cwd_hys_t;
  typedef enum logic [1:0] {EX_INIT = 2'b00, EX_RISE = 2'b01, EX_FALL = 2'b11} cwd_ex_t;
endpackage
